/* wdg_top.sv */
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module wdg_top #(
    parameter int LSO_DIV = wdg_pkg::LSO_DIV_CYCLES
) (
    // clock and power reset
    input  logic                clk_i,
    input  logic                rst_i,
    // wishbone slave
    input  wdg_pkg::wdg_wb_req_t wb_req_i,
    output logic [31:0]         wb_dat_o,
    output logic                wb_ack_o,
    // reset sources, asynchronous pins
    input  logic                imprecise_power_on_reset_i,
    input  logic                low_voltage_reset_i,
    input  logic                high_voltage_reset_i,
    input  logic                external_reset_low_n_i,
    input  logic                shared_reset_low_n_i,
    // power manager, same clock
    input  logic                shared_reset_en_i,
    input  logic                low_power_i,
    // reset result
    output logic                sys_reset_o,
    output logic                wdt_enabled_o
);
    import wdg_pkg::*;

    logic [15:0]      div_cnt;
    logic             lso_tick;
    logic [TW_W-1:0]  central_timewheel;
    logic [SYN_W-1:0] syn1;
    logic [SYN_W-1:0] syn2;
    logic [SYN_W-1:0] syn3;
    logic [SYN_W-1:0] pin_level;
    logic             power_rst;
    logic             ext_active;
    logic             hard_rst;
    logic [7:0]       soft_cnt;
    logic             soft_active;
    logic             soft_req;
    logic             sw_req;
    logic             local_rst;
    logic             acc;
    logic             wr;
    logic             rd;
    logic             wr_cfg;
    logic             wr_prot;
    logic             feed;
    logic [31:0]      next_rdata;
    logic [1:0]       interval;
    wdg_lp_t          lp_mode;
    logic             seg0_lock;
    logic             seg1_lock;
    logic             lp_q;
    logic             lp_entry;
    logic             forced_long;
    logic             halted;
    logic             running;
    logic [1:0]       eff_sel;
    logic             tap_now;
    logic             tap_q;
    logic             tap_event;
    logic [1:0]       wdt_cnt;
    logic             wdt_fire;
    logic             st_wdt;
    logic             st_sw;

    // low-speed oscillator stand-in: one tick per millisecond
    assign lso_tick = (div_cnt == 16'(LSO_DIV - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || lso_tick) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    // free-running, untouched by soft or pin resets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            central_timewheel <= '0;
        end else if (lso_tick) begin
            central_timewheel <= central_timewheel + 13'h0001;
        end
    end

    // pin synchronisers; a change counts once stages 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            syn1      <= '0;
            syn2      <= '0;
            syn3      <= '0;
            pin_level <= '0;
        end else begin
            syn1      <= {~shared_reset_low_n_i, ~external_reset_low_n_i, high_voltage_reset_i,
                          low_voltage_reset_i, imprecise_power_on_reset_i};
            syn2      <= syn1;
            syn3      <= syn2;
            pin_level <= (syn2 & syn3) | (pin_level & (syn2 ^ syn3));
        end
    end

    assign power_rst  = rst_i || pin_level[SYN_POR] || pin_level[SYN_LVR] || pin_level[SYN_HVR];
    assign ext_active = pin_level[SYN_EXT] || (pin_level[SYN_SHR] && shared_reset_en_i);
    assign hard_rst   = power_rst || ext_active;
    assign soft_req   = wdt_fire || sw_req;
    assign soft_active = (soft_cnt != 8'h00);
    // soft resets default the block but not the status or enable bits
    assign local_rst  = hard_rst || soft_req || soft_active;

    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            soft_cnt <= 8'h00;
        end else if (soft_req) begin
            soft_cnt <= SOFT_RST_CYCLES;
        end else if (soft_active) begin
            soft_cnt <= soft_cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b1;
        end else begin
            sys_reset_o <= hard_rst || soft_req || soft_active;
        end
    end

    // bus: registered ack one cycle after the request, unmapped reads zero
    assign acc     = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    assign wr      = acc && wb_req_i.we;
    assign rd      = acc && !wb_req_i.we;
    assign wr_cfg  = wr && (wb_req_i.adr == REG_CFG) && wb_req_i.sel[0] && !seg0_lock;
    assign wr_prot = wr && (wb_req_i.adr == REG_PROT) && wb_req_i.sel[0];
    assign feed    = wr && (wb_req_i.adr == REG_CLR) && !seg1_lock && !local_rst;
    assign sw_req  = wr && (wb_req_i.adr == REG_SWR) && wb_req_i.sel[0]
                     && wb_req_i.dat[SWR_BIT] && !hard_rst;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_req_i.adr)
            REG_CFG: begin
                next_rdata[CFG_SEL_LSB +: 2] = interval;
                next_rdata[CFG_EN_BIT]       = wdt_enabled_o;
                next_rdata[CFG_LP_LSB +: 2]  = lp_mode;
            end
            REG_ST0: begin
                next_rdata[ST0_WDT_BIT] = st_wdt;
                next_rdata[ST0_SW_BIT]  = st_sw;
            end
            REG_PROT: begin
                next_rdata[PROT_SEG0_BIT] = seg0_lock;
                next_rdata[PROT_SEG1_BIT] = seg1_lock;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            wb_dat_o <= next_rdata;
        end
    end

    // configuration; locked as a whole once segment 0 is set
    always_ff @(posedge clk_i) begin
        if (local_rst) begin
            interval <= CFG_SEL_RESET;
            lp_mode  <= LP_RESET;
        end else if (wr_cfg) begin
            interval <= wb_req_i.dat[CFG_SEL_LSB +: 2];
            lp_mode  <= wdg_lp_t'(wb_req_i.dat[CFG_LP_LSB +: 2]);
        end
    end

    // enable survives watchdog, software and external or shared pin resets; writing zero is ignored
    always_ff @(posedge clk_i) begin
        if (power_rst) begin
            wdt_enabled_o <= 1'b0;
        end else if (wr_cfg && wb_req_i.dat[CFG_EN_BIT]) begin
            wdt_enabled_o <= 1'b1;
        end
    end

    // segment 0 is one-time: set only, until the next reset
    always_ff @(posedge clk_i) begin
        if (local_rst) begin
            seg0_lock <= 1'b0;
            seg1_lock <= 1'b0;
        end else if (wr_prot) begin
            seg0_lock <= seg0_lock || wb_req_i.dat[PROT_SEG0_BIT];
            seg1_lock <= wb_req_i.dat[PROT_SEG1_BIT];
        end
    end

    assign lp_entry = low_power_i && !lp_q;

    // low-power handling; a halt ends only on a reset or on a feed made back in active mode
    always_ff @(posedge clk_i) begin
        if (local_rst) begin
            lp_q        <= low_power_i; // a reset ending in sleep is no new entry
            forced_long <= 1'b0;
            halted      <= 1'b0;
        end else begin
            lp_q <= low_power_i;
            if (lp_entry && wdt_enabled_o && lp_mode == WDG_LP_LONG) begin
                forced_long <= 1'b1;
            end else if (feed) begin
                forced_long <= 1'b0;
            end
            if (lp_entry && wdt_enabled_o && lp_mode == WDG_LP_HALT) begin
                halted <= 1'b1;
            end else if (feed && !low_power_i) begin
                halted <= 1'b0;
            end
        end
    end

    // keep and reserved codes change nothing on entry
    assign eff_sel = forced_long ? SEL_LONGEST : interval;
    assign running = wdt_enabled_o && !halted;

    always_comb begin
        case (eff_sel)
            2'h0:    tap_now = central_timewheel[TAP_BIT0];
            2'h1:    tap_now = central_timewheel[TAP_BIT1];
            2'h2:    tap_now = central_timewheel[TAP_BIT2];
            2'h3:    tap_now = central_timewheel[TAP_BIT3];
            default: tap_now = 1'b0;
        endcase
    end

    // switching taps may produce one early crossing; it only shortens a timeout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tap_q <= 1'b0;
        end else begin
            tap_q <= tap_now;
        end
    end

    assign tap_event = tap_now && !tap_q;

    // feed wins over a crossing in the same cycle
    always_ff @(posedge clk_i) begin
        if (local_rst) begin
            wdt_cnt  <= 2'h0;
            wdt_fire <= 1'b0;
        end else if (feed) begin
            wdt_cnt  <= 2'h0;
            wdt_fire <= 1'b0;
        end else if (tap_event && running) begin
            if (wdt_cnt == WDT_LAST) begin
                wdt_cnt  <= 2'h0;
                wdt_fire <= 1'b1;
            end else begin
                wdt_cnt  <= wdt_cnt + 2'h1;
                wdt_fire <= 1'b0;
            end
        end else begin
            wdt_fire <= 1'b0;
        end
    end

    // status: of the resets only hard ones clear; a set beats a bus clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (hard_rst) begin
            st_wdt <= 1'b0;
            st_sw  <= 1'b0;
        end else begin
            if (wdt_fire) begin
                st_wdt <= 1'b1;
            end else if (acc && wb_req_i.adr == REG_ST0) begin
                st_wdt <= 1'b0;
            end
            if (sw_req) begin
                st_sw <= 1'b1;
            end else if (wr && wb_req_i.adr == REG_ST0 && wb_req_i.sel[0] && wb_req_i.dat[ST0_SW_BIT]) begin
                st_sw <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_last_cross;
        tap_event && running && wdt_cnt == WDT_LAST && !feed && !local_rst;
    endsequence

    sequence s_fire_out;
        wdt_fire ##1 (sys_reset_o && soft_active);
    endsequence

    sequence s_lp_long_entry;
        lp_entry && wdt_enabled_o && lp_mode == WDG_LP_LONG && !local_rst;
    endsequence

    tw_step_a: assert property (lso_tick |=> central_timewheel == $past(central_timewheel) + 13'h0001)
        else $error("timewheel did not step on tick");

    tw_hold_a: assert property (!lso_tick |=> $stable(central_timewheel))
        else $error("timewheel moved without tick");

    tap_edge_a: assert property (tap_event |-> tap_now && !$past(tap_now) && eff_sel == $past(eff_sel)
        || tap_event && eff_sel != $past(eff_sel))
        else $error("crossing without rising tap");

    cnt_step_a: assert property (tap_event && running && wdt_cnt != WDT_LAST && !feed && !local_rst
        |=> wdt_cnt == $past(wdt_cnt) + 2'h1)
        else $error("count did not advance on crossing");

    cnt_idle_a: assert property (!tap_event && !feed && !local_rst |=> $stable(wdt_cnt))
        else $error("count moved without crossing");

    wdt_fire_a: assert property (s_last_cross |=> s_fire_out)
        else $error("third crossing gave no reset");

    fire_clear_a: assert property (s_last_cross |=> wdt_cnt == 2'h0)
        else $error("count not cleared after firing");

    feed_zero_a: assert property (feed && !local_rst |=> wdt_cnt == 2'h0 && !wdt_fire)
        else $error("service did not clear count");

    en_sticky_a: assert property (wdt_enabled_o && !power_rst |=> wdt_enabled_o)
        else $error("enable dropped without power reset");

    en_keep_a: assert property (wdt_fire && !power_rst |=> wdt_enabled_o [*2])
        else $error("watchdog reset cleared enable");

    lp_long_a: assert property (s_lp_long_entry |=> forced_long && eff_sel == SEL_LONGEST)
        else $error("longest interval not forced");

    lp_keep_a: assert property (lp_entry && lp_mode == WDG_LP_KEEP && !feed && !local_rst && !tap_event
        |=> $stable(forced_long) && $stable(halted) && $stable(wdt_cnt))
        else $error("keep mode altered watchdog");

    lp_halt_a: assert property (halted && !local_rst && !(feed && !low_power_i)
        |=> halted && !(wdt_fire))
        else $error("halted watchdog ran");

    seg_lock_a: assert property (seg0_lock && !local_rst |=> $stable(interval) && $stable(lp_mode))
        else $error("locked configuration changed");

    st_wdt_a: assert property (wdt_fire && !hard_rst |=> st_wdt)
        else $error("watchdog status not set");

    st_keep_a: assert property (st_wdt && !hard_rst && !acc |=> st_wdt)
        else $error("status lost without access");

    sw_rst_a: assert property (sw_req |=> sys_reset_o && st_sw ##1 sys_reset_o)
        else $error("software reset not taken");

    ext_hold_a: assert property (ext_active |=> sys_reset_o && !st_wdt && !st_sw)
        else $error("external reset not held");

endmodule

/* wdg_pkg.sv */
// How it works
// - free-running 13-bit timewheel steps at 1 kHz
// - each selected tap crossing bumps watchdog count
// - crossing at count two fires reset, count clears
// - a service returns the count to zero
// - enable bit sets once, only power reset clears
// - watchdog reset keeps the enable bit set
// - config bits 1:0 pick the timewheel tap
// - any write to clear register services watchdog
// - low-power field 01 forces longest interval until feed
// - low-power field 00 leaves watchdog untouched
// - low-power field 11 halts until first active feed
// - segment 0 locks config, segment 1 locks servicing
// - watchdog reset sets status bit 3, access clears
// - writing one to bit 0 forces soft reset
// - software reset sets status bit 5
// - external reset low holds device in reset
// - hard resets clear both status registers
// - soft resets keep both status registers
// - any reset restores registers except sticky bits
package wdg_pkg;

    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          LSO_PERIOD_NS   = 1000000;
    localparam int          LSO_DIV_CYCLES  = LSO_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          TW_W            = 13;
    localparam int          ADR_W           = 8;

    localparam logic [7:0]  REG_CFG         = 8'h00;
    localparam logic [7:0]  REG_CLR         = 8'h04;
    localparam logic [7:0]  REG_ST0         = 8'h08;
    localparam logic [7:0]  REG_ST1         = 8'h0c;
    localparam logic [7:0]  REG_SWR         = 8'h10;
    localparam logic [7:0]  REG_PROT        = 8'h14;

    localparam int          CFG_SEL_LSB     = 0;
    localparam int          CFG_EN_BIT      = 4;
    localparam int          CFG_LP_LSB      = 5;
    localparam logic [1:0]  CFG_SEL_RESET   = 2'h0;
    localparam logic [1:0]  SEL_LONGEST     = 2'h3;
    localparam int          ST0_WDT_BIT     = 3;
    localparam int          ST0_SW_BIT      = 5;
    localparam int          SWR_BIT         = 0;
    localparam int          PROT_SEG0_BIT   = 0;
    localparam int          PROT_SEG1_BIT   = 1;

    localparam logic [3:0]  TAP_BIT0        = 4'h3;
    localparam logic [3:0]  TAP_BIT1        = 4'h6;
    localparam logic [3:0]  TAP_BIT2        = 4'h9;
    localparam logic [3:0]  TAP_BIT3        = 4'hc;
    localparam logic [1:0]  WDT_LAST        = 2'h2;
    localparam logic [7:0]  SOFT_RST_CYCLES = 8'h10;

    localparam int          SYN_POR         = 0;
    localparam int          SYN_LVR         = 1;
    localparam int          SYN_HVR         = 2;
    localparam int          SYN_EXT         = 3;
    localparam int          SYN_SHR         = 4;
    localparam int          SYN_W           = 5;

    typedef enum logic [1:0] {
        WDG_LP_KEEP = 2'b00,
        WDG_LP_LONG = 2'b01,
        WDG_LP_RSVD = 2'b10,
        WDG_LP_HALT = 2'b11
    } wdg_lp_t;

    localparam wdg_lp_t     LP_RESET        = WDG_LP_LONG;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [3:0]       sel;
        logic [31:0]      dat;
    } wdg_wb_req_t;

endpackage

/* wdg_tb.sv */
`timescale 1ns/1ps
module testbench;
    import wdg_pkg::*;

    typedef struct {
        logic        we;
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [31:0] exp;
    } wdg_row_t;

    logic        clk_i         = 1'b0;
    logic        rst_i         = 1'b1;
    wdg_wb_req_t req           = '0;
    logic        por           = 1'b0;
    logic        lvr           = 1'b0;
    logic        hvr           = 1'b0;
    logic        ext_n         = 1'b1;
    logic        shr_n         = 1'b1;
    logic        shr_en        = 1'b0;
    logic        lp            = 1'b0;
    logic        prev_rst      = 1'b1;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sys_reset_o;
    logic        wdt_enabled_o;
    logic [31:0] q;
    int          n_mismatch    = 0;
    int          num_checks    = 0;
    int          fire_cnt      = 0;
    int          f;

    localparam int EXT_GAP_CYC = 10000 / CLK_PERIOD_NS;

    // short timewheel step so tap 0 period is 64 cycles
    wdg_top #(.LSO_DIV(4)) u_wdg_top (
        .clk_i                      (clk_i),
        .rst_i                      (rst_i),
        .wb_req_i                   (req),
        .wb_dat_o                   (wb_dat_o),
        .wb_ack_o                   (wb_ack_o),
        .imprecise_power_on_reset_i (por),
        .low_voltage_reset_i        (lvr),
        .high_voltage_reset_i       (hvr),
        .external_reset_low_n_i     (ext_n),
        .shared_reset_low_n_i       (shr_n),
        .shared_reset_en_i          (shr_en),
        .low_power_i                (lp),
        .sys_reset_o                (sys_reset_o),
        .wdt_enabled_o              (wdt_enabled_o)
    );

    always #12.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        prev_rst <= sys_reset_o;
        if (sys_reset_o === 1'b1 && prev_rst !== 1'b1) begin
            fire_cnt <= fire_cnt + 1;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %b", $time, msg, got);
        end
    endtask

    // classic single cycle; ack sampled at the edge, then released
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_i);
        req.cyc <= 1'b1;
        req.stb <= 1'b1;
        req.we  <= we;
        req.adr <= adr;
        req.sel <= 4'h1;
        req.dat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        chk_bit(wb_ack_o, 1'b1, "bus ack");
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        req.we  <= 1'b0;
    endtask

    task automatic feed();
        bus(1'b1, REG_CLR, 32'h5a, q);
    endtask

    // pin reassertion spacing; feeds keep the running watchdog quiet meanwhile
    task automatic ext_gap();
        repeat (EXT_GAP_CYC / 80 + 1) begin
            repeat (80) @(posedge clk_i);
            feed();
        end
    endtask

    task automatic quiet();
        int n;
        n = 0;
        while (sys_reset_o !== 1'b0 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        chk_bit(sys_reset_o, 1'b0, "reset release");
    endtask

    task automatic no_fire(input int cyc);
        int f0;
        f0 = fire_cnt;
        repeat (cyc) @(posedge clk_i);
        chk_bit(fire_cnt == f0, 1'b1, "unexpected reset");
    endtask

    // soft reset must start inside [lo,hi] cycles and last 17 cycles
    task automatic expect_fire(input int lo, input int hi);
        int n;
        n = 0;
        while (sys_reset_o !== 1'b1 && n <= hi) begin
            @(posedge clk_i);
            n++;
        end
        chk_bit(n >= lo && n <= hi, 1'b1, "reset moment");
        n = 0;
        while (sys_reset_o === 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk_val(32'(n), 32'd17, "soft reset length");
    endtask

    wdg_row_t rows[] = '{
        '{1'b0, REG_CFG, 32'h0, 32'h20}, '{1'b0, REG_CLR, 32'h0, 32'h0},
        '{1'b0, REG_ST0, 32'h0, 32'h0},  '{1'b0, REG_ST1, 32'h0, 32'h0},
        '{1'b1, 8'h1c, 32'hff, 32'h0},   '{1'b0, 8'h1c, 32'h0, 32'h0},
        '{1'b1, REG_CFG, 32'h62, 32'h0}, '{1'b0, REG_CFG, 32'h0, 32'h62},
        '{1'b1, REG_CFG, 32'h20, 32'h0}, '{1'b1, REG_PROT, 32'h2, 32'h0},
        '{1'b0, REG_PROT, 32'h0, 32'h2}, '{1'b1, REG_PROT, 32'h0, 32'h0},
        '{1'b0, REG_PROT, 32'h0, 32'h0}
    };

    initial begin
        #(20000 * 25);
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog timeout", $time);
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        quiet();
        foreach (rows[i]) begin
            bus(rows[i].we, rows[i].adr, rows[i].dat, q);
            if (!rows[i].we) chk_val(q, rows[i].exp, "register table");
        end
        $display("test registers done");
        bus(1'b1, REG_CFG, 32'h30, q);
        bus(1'b1, REG_CFG, 32'h20, q);
        bus(1'b0, REG_CFG, 32'h0, q);
        chk_val(q, 32'h30, "enable not sticky");
        chk_bit(wdt_enabled_o, 1'b1, "enable output");
        repeat (6) begin
            no_fire(90);
            feed();
        end
        expect_fire(120, 200);
        chk_bit(wdt_enabled_o, 1'b1, "enable lost on watchdog reset");
        bus(1'b0, REG_ST0, 32'h0, q);
        chk_val(q, 32'h08, "watchdog status");
        bus(1'b0, REG_ST0, 32'h0, q);
        chk_val(q, 32'h0, "status not cleared by read");
        bus(1'b0, REG_CFG, 32'h0, q);
        chk_val(q, 32'h30, "config after soft reset");
        $display("test timeout done");
        bus(1'b1, REG_CFG, 32'h70, q);
        feed();
        lp <= 1'b1;
        no_fire(400);
        lp <= 1'b0;
        no_fire(300);
        feed();
        expect_fire(120, 200);
        feed();
        lp <= 1'b1;
        no_fire(1000);
        lp <= 1'b0;
        no_fire(400);
        feed();
        expect_fire(60, 200);
        bus(1'b1, REG_CFG, 32'h10, q);
        feed();
        lp <= 1'b1;
        expect_fire(120, 200);
        lp <= 1'b0;
        $display("test low power done");
        feed();
        bus(1'b1, REG_SWR, 32'h1, q);
        expect_fire(0, 4);
        bus(1'b0, REG_ST0, 32'h0, q);
        // watchdog flag from the low-power fires is still held
        chk_val(q, 32'h28, "software status");
        bus(1'b1, REG_ST0, 32'h20, q);
        bus(1'b0, REG_ST0, 32'h0, q);
        chk_val(q, 32'h0, "software status clear");
        $display("test software reset done");
        feed();
        bus(1'b1, REG_PROT, 32'h2, q);
        f = fire_cnt;
        repeat (4) begin
            repeat (50) @(posedge clk_i);
            feed();
        end
        chk_bit(fire_cnt != f, 1'b1, "locked feed accepted");
        quiet();
        bus(1'b0, REG_PROT, 32'h0, q);
        chk_val(q, 32'h0, "protection after reset");
        feed();
        bus(1'b1, REG_PROT, 32'h1, q);
        bus(1'b1, REG_CFG, 32'h73, q);
        bus(1'b0, REG_CFG, 32'h0, q);
        chk_val(q, 32'h30, "locked config written");
        $display("test protection done");
        bus(1'b1, REG_SWR, 32'h1, q);
        expect_fire(0, 4);
        ext_n <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk_bit(sys_reset_o, 1'b1, "external reset");
        ext_n <= 1'b1;
        quiet();
        chk_bit(wdt_enabled_o, 1'b1, "enable after external reset");
        bus(1'b0, REG_ST0, 32'h0, q);
        chk_val(q, 32'h0, "status after hard reset");
        ext_gap();
        shr_n <= 1'b0;
        no_fire(20);
        shr_n <= 1'b1;
        ext_gap();
        shr_en <= 1'b1;
        shr_n  <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk_bit(sys_reset_o, 1'b1, "shared reset");
        shr_n  <= 1'b1;
        shr_en <= 1'b0;
        quiet();
        $display("test external reset done");
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, REG_CFG, 32'h30, q);
            case (i)
                0: por <= 1'b1;
                1: lvr <= 1'b1;
                default: hvr <= 1'b1;
            endcase
            repeat (12) @(posedge clk_i);
            chk_bit(sys_reset_o, 1'b1, "power reset");
            por <= 1'b0;
            lvr <= 1'b0;
            hvr <= 1'b0;
            quiet();
            chk_bit(wdt_enabled_o, 1'b0, "enable after power reset");
        end
        bus(1'b1, REG_CFG, 32'h31, q);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        quiet();
        chk_bit(wdt_enabled_o, 1'b0, "enable after rst");
        bus(1'b0, REG_CFG, 32'h0, q);
        chk_val(q, 32'h20, "config after rst");
        $display("test hard resets done");
        end_sim();
    end
endmodule
